// ===== hdl/sdpci_pkg.sv
// shared constants, types and encodings for the sdram pin command interface
package sdpci_pkg;

  // ==========================================================================
  // pin widths
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int COL_W = 11;
  localparam int MODE_W = BA_W + ADDR_W;

  // ==========================================================================
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // ==========================================================================
  // address and mode field positions
  localparam int AUTO_PRE_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WB_BIT = 9;

  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;

  // ==========================================================================
  // page masks per organisation
  localparam logic [COL_W-1:0] PAGE_MASK_X4 = 11'h7FF;
  localparam logic [COL_W-1:0] PAGE_MASK_X8 = 11'h3FF;
  localparam logic [COL_W-1:0] PAGE_MASK_X16 = 11'h1FF;

  // ==========================================================================
  // reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 15'h0020;
  localparam logic [COL_W-1:0] BEAT_ONE = 11'h001;

  // ==========================================================================
  // types
  typedef enum logic [4:0] {
    PWR_RUN = 5'h01,
    PWR_SUSPEND = 5'h02,
    PWR_PD_PRE = 5'h04,
    PWR_PD_ACT = 5'h08,
    PWR_SELF = 5'h10
  } sdpci_pwr_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdpci_pins_t;

  // clock enable resets high, so leaving reset is not taken as a power-down request
  localparam sdpci_pins_t PINS_RESET = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                         we_n: 1'b1, ba: 2'h0, addr: 13'h0000};

endpackage

// ===== hdl/sdpci_array.sv
// storage array with per-lane write enables and registered read
`timescale 1ns/100ps
module sdpci_array #(
  parameter int DQ_W = 8,
  parameter int LANES = 1,
  parameter int AW = 12
) (
  input wire logic clk_sys, // core clock
  input wire logic wr_en, // write one beat
  input wire logic [LANES-1:0] lane_en, // lanes allowed to change
  input wire logic [AW-1:0] addr, // beat location
  input wire logic [DQ_W-1:0] wdata, // write beat
  input wire logic rd_en, // read one beat
  output logic [DQ_W-1:0] rdata // read beat, one edge after rd_en
);
  localparam int LANE_W = DQ_W / LANES;

  logic [DQ_W-1:0] mem [2**AW];

  // ==========================================================================
  // write with lane masking
  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en && lane_en[l]) begin
        mem[addr][l*LANE_W +: LANE_W] <= wdata[l*LANE_W +: LANE_W];
      end
    end
  end

  // ==========================================================================
  // registered read
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end
endmodule // sdpci_array

// ===== hdl/sdpci_device.sv
// sdram pin command interface, device end: input registers, decode, bursts, data pins
// ============================================================================
// Overview of operation
// - every pin is registered on the rising clock; the same clock drives bursts and outputs
// - clock enable low gates the internal clock: power-down, self refresh or suspend
// - in power-down and self refresh only clock enable is watched; other inputs are off
// - chip select high blocks new commands; running bursts and data mask carry on
// - the command is the code of chip select, row, column and write strobes
// - a write beat with its data mask high leaves the array unchanged
// - a read data mask high turns the data outputs off two clocks later
// - the bank inputs pick the bank; with a mode load they are op-code bits
// - activate captures the full thirteen-bit row into the chosen bank
// - start column: bits 0-9 and 11 by-4, bits 0-9 by-8, bits 0-8 by-16
// - address bit 10 with read or write asks for precharge at burst end
// - precharge with bit 10 high closes all banks, low only the named bank
// - mode load takes the op-code from the address and bank inputs
// - data bus is four bits wide by-4 and eight bits wide by-8
// - by-16 has a lower mask for bits 0-7 and an upper one for 8-15
`timescale 1ns/100ps
module sdpci_device import sdpci_pkg::*; #(
  parameter int DQ_W = 8, // 4, 8 or 16
  parameter int ROW_KEEP = 4, // row bits that reach the array
  parameter int COL_KEEP = 6 // column bits that reach the array
) (
  input wire logic clk_sys, // memory clock
  input wire logic reset, // asynchronous, active high
  input wire logic cke, // clock enable pin
  input wire logic cs_n, // chip select, active low
  input wire logic ras_n, // row strobe, active low
  input wire logic cas_n, // column strobe, active low
  input wire logic we_n, // write strobe, active low
  input wire logic [BA_W-1:0] ba, // bank address
  input wire logic [ADDR_W-1:0] addr, // address / op-code
  input wire logic lower_byte_mask, // data mask, low lane
  input wire logic upper_byte_mask, // data mask, high lane (by-16 only)
  input wire logic [DQ_W-1:0] dq_in, // data bus, input side
  output logic [DQ_W-1:0] dq_out, // data bus, output side
  output logic [DQ_W-1:0] dq_oe, // data bus drive enable per bit
  output sdpci_pwr_t pwr_mode // current power / clock state
);
  localparam int LANES = (DQ_W == 16) ? 2 : 1;
  localparam int LANE_W = DQ_W / LANES;
  localparam int AW = BA_W + ROW_KEEP + COL_KEEP;
  localparam logic [COL_W-1:0] PAGE_MASK = (DQ_W == 4) ? PAGE_MASK_X4 :
                                          (DQ_W == 8) ? PAGE_MASK_X8 : PAGE_MASK_X16;

  // ==========================================================================
  // functions
  function automatic logic [COL_W-1:0] col_of(input logic [ADDR_W-1:0] a);
    if (DQ_W == 4) begin
      col_of = {a[11], a[9:0]};
    end else if (DQ_W == 8) begin
      col_of = {1'b0, a[9:0]};
    end else begin
      col_of = {2'b00, a[8:0]};
    end
  endfunction

  function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] code);
    case (code)
      BL_2: bl_mask = 11'h001;
      BL_4: bl_mask = 11'h003;
      BL_8: bl_mask = 11'h007;
      BL_PAGE: bl_mask = PAGE_MASK;
      default: bl_mask = 11'h000;
    endcase
  endfunction

  // burst wraps inside the block chosen by the start column
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] cnt,
                                                 input logic [COL_W-1:0] m,
                                                 input logic inter);
    logic [COL_W-1:0] low;
    low = inter ? (start ^ cnt) : COL_W'(start + cnt);
    burst_col = (start & ~m) | (low & m);
  endfunction

  function automatic logic [DQ_W-1:0] lane_expand(input logic [LANES-1:0] m);
    logic [DQ_W-1:0] e;
    e = '0;
    for (int i = 0; i < DQ_W; i++) begin
      e[i] = m[i / LANE_W];
    end
    lane_expand = e;
  endfunction

  // ==========================================================================
  // input registers
  sdpci_pins_t pin_q;
  logic [LANES-1:0] mask_q;
  logic [DQ_W-1:0] dq_q;
  logic [LANES-1:0] mask_in;
  logic buffers_off;

  assign mask_in = (LANES == 2) ? LANES'({upper_byte_mask, lower_byte_mask}) :
                                  LANES'(lower_byte_mask);
  assign buffers_off = (pwr_mode == PWR_PD_PRE) || (pwr_mode == PWR_PD_ACT) ||
                       (pwr_mode == PWR_SELF);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_q <= PINS_RESET;
      mask_q <= '0;
      dq_q <= '0;
    end else begin
      pin_q.cke <= cke;
      // input buffers are dark in power-down; only clock enable gets through
      if (!buffers_off) begin
        pin_q.cs_n <= cs_n;
        pin_q.ras_n <= ras_n;
        pin_q.cas_n <= cas_n;
        pin_q.we_n <= we_n;
        pin_q.ba <= ba;
        pin_q.addr <= addr;
        mask_q <= mask_in;
        dq_q <= dq_in;
      end else begin
        // dark buffers read as deselect, so no stale command replays on wake
        pin_q.cs_n <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // command decode
  logic [3:0] cmd;
  logic run;
  logic cmd_live;
  logic rw_cmd;

  assign cmd = {pin_q.cs_n, pin_q.ras_n, pin_q.cas_n, pin_q.we_n};
  assign run = (pwr_mode == PWR_RUN) && pin_q.cke;
  assign cmd_live = run && !pin_q.cs_n;
  assign rw_cmd = cmd_live && ((cmd == CMD_READ) || (cmd == CMD_WRITE));

  // ==========================================================================
  // mode register and banks
  logic [MODE_W-1:0] mode_reg;
  logic [NUM_BANKS-1:0] bank_open;
  logic [ADDR_W-1:0] bank_row [NUM_BANKS];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_reg <= MODE_RESET;
    end else if (cmd_live && cmd == CMD_LMR) begin
      mode_reg <= {pin_q.ba, pin_q.addr};
    end
  end

  // ==========================================================================
  // burst engine
  logic rd_busy;
  logic wr_busy;
  logic bst_full;
  logic bst_ap;
  logic [BA_W-1:0] bst_bank;
  logic [COL_W-1:0] bst_start;
  logic [COL_W-1:0] bst_cnt;
  logic [COL_W-1:0] bst_mask;
  logic beat_go;
  logic beat_wr;
  logic beat_last;
  logic beat_ap;
  logic [BA_W-1:0] beat_bank;
  logic [COL_W-1:0] beat_col;
  logic [COL_W-1:0] beat_mask;
  logic single_wr;

  assign single_wr = (cmd == CMD_WRITE) && mode_reg[MR_WB_BIT];

  always_comb begin
    beat_go = 1'b0;
    beat_wr = wr_busy;
    beat_bank = bst_bank;
    beat_col = burst_col(bst_start, bst_cnt, bst_mask, mode_reg[MR_BT_BIT]);
    beat_mask = bst_mask;
    beat_last = !bst_full && (bst_cnt == bst_mask);
    beat_ap = bst_ap;
    if (rw_cmd) begin
      // a new read or write cuts off any burst still running
      beat_go = 1'b1;
      beat_wr = (cmd == CMD_WRITE);
      beat_bank = pin_q.ba;
      beat_col = col_of(pin_q.addr);
      beat_mask = single_wr ? '0 : bl_mask(mode_reg[MR_BL_LSB +: 3]);
      beat_last = (beat_mask == '0);
      beat_ap = pin_q.addr[AUTO_PRE_BIT];
    end else if (run && (rd_busy || wr_busy) && !(cmd_live && cmd == CMD_BURST_STOP)) begin
      beat_go = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_busy <= 1'b0;
      wr_busy <= 1'b0;
      bst_full <= 1'b0;
      bst_ap <= 1'b0;
      bst_bank <= '0;
      bst_start <= '0;
      bst_cnt <= '0;
      bst_mask <= '0;
    end else if (rw_cmd) begin
      rd_busy <= !beat_wr && !beat_last;
      wr_busy <= beat_wr && !beat_last;
      bst_full <= !single_wr && (mode_reg[MR_BL_LSB +: 3] == BL_PAGE);
      bst_ap <= beat_ap;
      bst_bank <= beat_bank;
      bst_start <= beat_col;
      bst_cnt <= BEAT_ONE;
      bst_mask <= beat_mask;
    end else if (cmd_live && cmd == CMD_BURST_STOP) begin
      rd_busy <= 1'b0;
      wr_busy <= 1'b0;
    end else if (beat_go) begin
      bst_cnt <= COL_W'(bst_cnt + BEAT_ONE);
      if (beat_last) begin
        rd_busy <= 1'b0;
        wr_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bank_open <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_row[b] <= '0;
      end
    end else begin
      if (beat_go && beat_last && beat_ap) begin
        bank_open[beat_bank] <= 1'b0;
      end
      if (cmd_live && cmd == CMD_PRECHARGE) begin
        if (pin_q.addr[AUTO_PRE_BIT]) begin
          bank_open <= '0;
        end else begin
          bank_open[pin_q.ba] <= 1'b0;
        end
      end else if (cmd_live && cmd == CMD_ACTIVE) begin
        bank_open[pin_q.ba] <= 1'b1;
        bank_row[pin_q.ba] <= pin_q.addr;
      end
    end
  end

  // ==========================================================================
  // power and clock gating
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwr_mode <= PWR_RUN;
    end else begin
      case (pwr_mode)
        PWR_RUN: begin
          if (!pin_q.cke) begin
            if (!pin_q.cs_n && cmd == CMD_REFRESH) begin
              pwr_mode <= PWR_SELF;
            end else if (rd_busy || wr_busy) begin
              pwr_mode <= PWR_SUSPEND;
            end else if (bank_open != '0) begin
              pwr_mode <= PWR_PD_ACT;
            end else begin
              pwr_mode <= PWR_PD_PRE;
            end
          end
        end
        default: begin
          if (pin_q.cke) begin
            pwr_mode <= PWR_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // array
  logic [AW-1:0] arr_addr;
  logic [DQ_W-1:0] arr_rdata;
  logic [ADDR_W-1:0] beat_row;

  assign beat_row = bank_row[beat_bank];
  // only a slice of row and column is stored, so distant locations alias
  assign arr_addr = {beat_bank, beat_row[ROW_KEEP-1:0], beat_col[COL_KEEP-1:0]};

  sdpci_array #(.DQ_W(DQ_W), .LANES(LANES), .AW(AW)) u_array (
    .clk_sys(clk_sys),
    .wr_en(beat_go && beat_wr),
    .lane_en(~mask_q),
    .addr(arr_addr),
    .wdata(dq_q),
    .rd_en(beat_go && !beat_wr),
    .rdata(arr_rdata)
  );

  // ==========================================================================
  // read pipeline and data pins
  logic p0_valid;
  logic p1_valid;
  logic [DQ_W-1:0] p1_data;
  logic [LANES-1:0] mask_d1;
  logic out_valid;
  logic [DQ_W-1:0] out_data;

  assign out_valid = (mode_reg[MR_CL_LSB +: 3] == CL_3) ? p1_valid : p0_valid;
  assign out_data = (mode_reg[MR_CL_LSB +: 3] == CL_3) ? p1_data : arr_rdata;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      p0_valid <= 1'b0;
      p1_valid <= 1'b0;
      p1_data <= '0;
      mask_d1 <= '0;
    end else if (run) begin
      p0_valid <= beat_go && !beat_wr;
      p1_valid <= p0_valid;
      p1_data <= arr_rdata;
      mask_d1 <= mask_q;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dq_out <= '0;
      dq_oe <= '0;
    end else if (buffers_off) begin
      dq_oe <= '0;
    end else if (run) begin
      // suspend freezes the pins, so a held beat stays driven
      if (out_valid) begin
        dq_out <= out_data;
      end
      dq_oe <= out_valid ? ~lane_expand(mask_d1) : '0;
    end
  end
endmodule // sdpci_device

// ===== verif/sdpci_checker.sv
// pin-level assertions for the sdram device end
`timescale 1ns/100ps
module sdpci_checker import sdpci_pkg::*; #(
  parameter int DQ_W = 8
) (
  input wire logic clk_sys, // clock
  input wire logic reset, // reset
  input wire logic cke, // clock enable
  input wire logic cs_n, // select
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write strobe
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic lower_byte_mask, // mask
  input wire logic [DQ_W-1:0] dq_oe, // drive enable
  input sdpci_pwr_t pwr_mode // power state
);
  // ====================
  // helpers
  logic [3:0] cmd;
  logic take;
  logic cl3;
  logic [4:0] rd_age;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign take = cke && pwr_mode == PWR_RUN;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      cl3 <= 1'b0;
    else if (take && cmd == CMD_LMR)
      cl3 <= addr[6:4] == CL_3;
  end
  // gated cycles do not age, so suspended bursts stay legal
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      rd_age <= 5'h1F;
    else if (take && cmd == CMD_READ)
      rd_age <= 5'h00;
    else if (cke && rd_age != 5'h1F)
      rd_age <= rd_age + 5'h01;
  end
  // ====================
  // assertions
  AST_MASK_HIZ: assert property (@(posedge clk_sys) disable iff (reset)
    lower_byte_mask && cke ##1 cke [*2] |=> dq_oe == '0)
    else $error("data driven after read mask");
  AST_READ_CL2: assert property (@(posedge clk_sys) disable iff (reset)
    take && $past(cke) && cmd == CMD_READ && !cl3 && !lower_byte_mask ##1 cke [*2]
    |=> dq_oe == '1)
    else $error("first read beat missing at latency two");
  AST_READ_CL3: assert property (@(posedge clk_sys) disable iff (reset)
    take && $past(cke) && cmd == CMD_READ && cl3 ##1 cke && !lower_byte_mask ##1 cke [*2]
    |=> dq_oe == '1)
    else $error("first read beat missing at latency three");
  AST_GATED_CKE: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_mode != PWR_RUN |-> !$past(cke, 2))
    else $error("gated state without clock enable low");
  AST_WAKE: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_mode inside {PWR_PD_PRE, PWR_PD_ACT, PWR_SELF} && cke |-> ##2 pwr_mode == PWR_RUN)
    else $error("no exit from power-down");
  AST_PD_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_mode inside {PWR_PD_PRE, PWR_PD_ACT, PWR_SELF} |-> dq_oe == '0)
    else $error("data driven in power-down");
  AST_SELF_ENTRY: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_mode == PWR_RUN && $past(cke) && !cke && cmd == CMD_REFRESH && dq_oe == '0
    |-> ##2 pwr_mode == PWR_SELF)
    else $error("self refresh not entered");
  AST_NO_STRAY_DRIVE: assert property (@(posedge clk_sys) disable iff (reset)
    dq_oe != '0 |-> rd_age <= 5'h0C)
    else $error("data driven without an accepted read");
  cover property (@(posedge clk_sys) disable iff (reset) take && cmd == CMD_READ);
  cover property (@(posedge clk_sys) disable iff (reset) pwr_mode == PWR_SUSPEND);
  cover property (@(posedge clk_sys) disable iff (reset) pwr_mode == PWR_PD_ACT);
endmodule // sdpci_checker

bind sdpci_device sdpci_checker #(.DQ_W(DQ_W)) chk_u (.clk_sys(clk_sys), .reset(reset),
  .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
  .lower_byte_mask(lower_byte_mask), .dq_oe(dq_oe), .pwr_mode(pwr_mode));

// ===== verif/sdpci_ctrl_model.sv
// controller model: command pins and the shared data bus
`timescale 1ns/100ps
module sdpci_ctrl_model import sdpci_pkg::*; (
  input wire logic clk_sys, // clock
  input wire logic req_valid, // command meant this cycle
  input sdpci_pins_t req, // requested pins
  input wire logic wr_drive, // drive write data
  input wire logic [7:0] wr_data, // write data
  input wire logic [7:0] dq_out, // device data
  input wire logic [7:0] dq_oe, // device drive enable
  output sdpci_pins_t pins, // to the device
  output logic [7:0] dq_in // resolved bus
);
  logic idle_pick = 1'b1;
  logic [7:0] last = 8'h5A;
  always @(negedge clk_sys)
    idle_pick <= !idle_pick;
  always_comb begin
    pins = req;
    if (!req_valid) begin
      pins.cs_n = idle_pick;
      {pins.ras_n, pins.cas_n, pins.we_n} = 3'h7;
    end
  end
  // undriven bus shows the inverse of its last level, never a stale copy
  always @(negedge clk_sys)
    last <= dq_in;
  always_comb
    for (int i = 0; i < 8; i++)
      dq_in[i] = dq_oe[i] ? dq_out[i] : (wr_drive ? wr_data[i] : !last[i]);
endmodule // sdpci_ctrl_model

// ===== verif/tb.sv
// self-checking bench for the sdram device end
`timescale 1ns/100ps
module tb import sdpci_pkg::*; ;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  sdpci_pins_t req = PINS_RESET;
  logic wr_drive = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [1:0] mask = 2'h0;
  sdpci_pins_t pins;
  logic [7:0] dq_in;
  logic [7:0] dq_out;
  logic [7:0] dq_oe;
  sdpci_pwr_t pwr_mode;
  logic [7:0] ref_mem [0:511];
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'hE1088FCA;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #2 clk_sys = !clk_sys;
  sdpci_device #(.DQ_W(8)) dut_u (.clk_sys(clk_sys), .reset(reset), .cke(pins.cke),
    .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
    .ba(pins.ba), .addr(pins.addr), .lower_byte_mask(mask[0]), .upper_byte_mask(mask[1]),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .pwr_mode(pwr_mode));
  sdpci_ctrl_model ctl_u (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
    .wr_drive(wr_drive), .wr_data(wr_data), .dq_out(dq_out), .dq_oe(dq_oe),
    .pins(pins), .dq_in(dq_in));
  // ====================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ====================
  // bus tasks, inputs change at the falling edge
  task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a);
    @(negedge clk_sys);
    req_valid = 1'b1;
    {req.cs_n, req.ras_n, req.cas_n, req.we_n} = code;
    req.ba = b;
    req.addr = a;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      req_valid = 1'b0;
      wr_drive = 1'b0;
      mask = {seed[3], 1'b0};
      seed = lfsr(seed);
    end
  endtask
  task automatic wr2(input int b, input logic [12:0] a, input logic [8:0] ix,
                     input logic [15:0] d, input logic [1:0] m);
    issue(CMD_WRITE, b[1:0], a);
    wr_drive = 1'b1;
    wr_data = d[7:0];
    mask[0] = m[0];
    @(negedge clk_sys);
    req_valid = 1'b0;
    wr_data = d[15:8];
    mask[0] = m[1];
    if (!m[0])
      ref_mem[ix] = d[7:0];
    if (!m[1])
      ref_mem[ix + 9'h001] = d[15:8];
  endtask
  // beat masks line up with latency two only
  task automatic rd2(input int b, input logic [12:0] a, input logic [8:0] ix,
                     input logic [1:0] m);
    issue(CMD_READ, b[1:0], a);
    mask[0] = m[0];
    if (!m[0])
      exp_q.push_back(ref_mem[ix]);
    if (!m[1])
      exp_q.push_back(ref_mem[ix + 9'h001]);
    @(negedge clk_sys);
    req_valid = 1'b0;
    mask[0] = m[1];
  endtask
  task automatic pd(input logic [3:0] code, input sdpci_pwr_t exp);
    issue(code, 2'h0, 13'h0000);
    req.cke = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(8'(pwr_mode), 8'(exp));
    req_valid = 1'b0;
    req.cke = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(8'(pwr_mode), 8'(PWR_RUN));
  endtask
  // ====================
  // read beat monitor
  always @(negedge clk_sys)
    if (!reset && dq_oe !== 8'h00) begin
      if (exp_q.size() == 0)
        check(dq_oe, 8'h00);
      else begin
        check(dq_oe, 8'hFF);
        check(dq_out, exp_q.pop_front());
      end
    end
  // ====================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    req.cke = 1'b1;
    issue(CMD_LMR, 2'h0, 13'h0021);
    idle(2);
    for (int p = 0; p < 3; p++)
      for (int r = 0; r < 2; r++) begin
        for (int b = 0; b < 4; b++) begin
          issue(CMD_ACTIVE, b[1:0], {12'hF80, r[0]});
          idle(1);
        end
        for (int b = 0; b < 4; b++) begin
          if (p < 2)
            wr2(b, {seed[20:19], 11'h010}, {b[1:0], r[0], 6'h10}, seed[15:0],
                p[0] ? seed[17:16] : 2'h0);
          else
            rd2(b, {seed[20:19], 11'h010}, {b[1:0], r[0], 6'h10}, seed[1:0]);
          seed = lfsr(seed);
        end
        idle(4);
        issue(CMD_PRECHARGE, 2'h0, 13'h0400);
        idle(1);
      end
    $display("end write read masks");
    issue(CMD_ACTIVE, 2'h0, 13'h1F00);
    idle(1);
    rd2(0, 13'h0010, 9'h010, 2'h2);
    issue({1'b1, CMD_READ[2:0]}, 2'h0, 13'h0010);
    idle(4);
    rd2(0, 13'h0010, 9'h010, 2'h0);
    req.cke = 1'b0;
    repeat (2) @(negedge clk_sys);
    req.cke = 1'b1;
    idle(4);
    $display("end deselect suspend");
    pd(CMD_READ, PWR_PD_ACT);
    issue(CMD_LMR, 2'h0, 13'h0031);
    idle(2);
    rd2(0, 13'h0010, 9'h010, 2'h0);
    idle(5);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400);
    pd(CMD_READ, PWR_PD_PRE);
    issue(CMD_ACTIVE, 2'h1, 13'h1F00);
    issue(CMD_ACTIVE, 2'h2, 13'h1F00);
    issue(CMD_PRECHARGE, 2'h1, 13'h0000);
    pd(CMD_READ, PWR_PD_ACT);
    issue(CMD_PRECHARGE, 2'h2, 13'h0000);
    pd(CMD_READ, PWR_PD_PRE);
    issue(CMD_ACTIVE, 2'h3, 13'h1F01);
    idle(1);
    rd2(3, 13'h0410, 9'h1D0, 2'h0);
    idle(6);
    pd(CMD_READ, PWR_PD_PRE);
    pd(CMD_REFRESH, PWR_SELF);
    $display("end power modes");
    idle(6);
    check(8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule // tb
